// file: verilog/amg_cfg.svh
// amg_cfg.svh: offsets, field positions, reset values and gain codes of the mixer bank
// assumes: included by bare name from the package and the register bank
`ifndef AMG_CFG_SVH
`define AMG_CFG_SVH

// register offsets
`define AMG_AUX_B_OFS        8'h5d
`define AMG_LOUT_OFS         8'h60
`define AMG_ROUT_OFS         8'h61
`define AMG_LIN_OFS          8'h62

// writable-bit masks; every other bit reads zero
`define AMG_AUX_B_MASK       16'h9e07
`define AMG_LOUT_MASK        16'h0eee
`define AMG_ROUT_MASK        16'he0ee
`define AMG_LIN_MASK         16'h0e0f

// reset values
`define AMG_REG_RST          16'h0000

// single-bit positions in the auxiliary-b control register
`define AMG_AUX_B_ENA_BIT    15
`define AMG_R_CONV_BIT       12
`define AMG_L_CONV_BIT       11
`define AMG_CUT_BIT          10
`define AMG_R_REC_BIT        9
`define AMG_AUX_A_BIT        2
`define AMG_R_OUT_BIT        1
`define AMG_L_OUT_BIT        0

// gain field low-bit positions and the left record boost bit
`define AMG_F_HI_LO          9
`define AMG_F_TOP_LO         13
`define AMG_F_MID_LO         5
`define AMG_F_LOW_LO         1
`define AMG_BOOST_BIT        0

// gain decode: code 0 mutes, else dB = base + step * code
`define AMG_GAIN_OFF         3'h0
`define AMG_GAIN_BASE_DB     6'sh31
`define AMG_GAIN_STEP_DB     6'sh03
`define AMG_GAIN_MAX         3'h7

`endif

// file: verilog/amg_pkg.sv
// amg_pkg.sv: types of the mixer route and gain register bank
// assumes: amg_cfg.svh on the include path
`include "amg_cfg.svh"
`default_nettype none

package amg_pkg;

    typedef logic signed [5:0] amg_db_t;

    // whole state of the bank in one word
    typedef struct packed {
        logic [15:0]      aux_b;
        logic [15:0]      lout;
        logic [15:0]      rout;
        logic [15:0]      lin;
        logic [15:0]      rd_data;
        logic             rd_valid;
        logic [7:0]       path_on;
        amg_db_t [7:0]    gain_db;
    } amg_state_t;

endpackage : amg_pkg

`default_nettype wire

// file: verilog/amg_regs.sv
// amg_regs.sv: mixer routing and gain register bank with decoded control outputs
// assumes: host access is synchronous to clk; at most one write and one read per cycle
// assumes: amg_cfg.svh on the include path
//
// Contract
// - bit 15 of aux-b control enables the aux-b mixer, resets zero
// - bit 12 routes the right converter into aux-b, resets zero
// - bit 11 routes the left converter into aux-b, resets zero
// - bit 10 cuts aux-b output level by 6dB when set
// - bit 9 routes the right record mixer into aux-b, resets zero
// - bit 1 routes the right output mixer into aux-b, resets zero
// - bit 0 routes the left output mixer into aux-b, resets zero
// - gain code 000 disconnects, 001 -12dB, 010 -9dB, 111 +6dB; reset 000
// - left output gains at bits 11:9, 7:5 and 3:1
// - right output gains at bits 15:13, 7:5 and 3:1
// - left record gains at bits 11:9 and 3:1
// - left record bit 0 selects +0dB or +20dB amplifier boost
`include "amg_cfg.svh"
`default_nettype none

module amg_regs (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // host register port
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    input  wire logic [7:0]               addr,
    input  wire logic [15:0]              wr_data,
    output logic      [15:0]              rd_data,
    output logic                          rd_valid,
    // aux-b routing
    output logic                          aux_b_mixer_enable,
    output logic                          right_converter_to_aux_b,
    output logic                          left_converter_to_aux_b,
    output logic                          aux_b_six_db_cut,
    output logic                          right_record_mix_to_aux_b,
    output logic                          right_out_mix_to_aux_b,
    output logic                          left_out_mix_to_aux_b,
    // gain paths: 0 third_left_in_to_left_out, 1 right_amp_to_left_out,
    // 2 left_amp_to_left_out, 3 third_right_in_to_right_out, 4 right_amp_to_right_out,
    // 5 left_amp_to_right_out, 6 third_left_in_to_record, 7 second_left_in_to_record
    output logic      [7:0]               path_on,
    output amg_pkg::amg_db_t [7:0]        gain_db,
    output logic                          left_amp_record_boost
);

    amg_pkg::amg_state_t st_ff;
    amg_pkg::amg_state_t nxt_st;
    logic [7:0][2:0]     code;
    logic [7:0]          dec_on;
    amg_pkg::amg_db_t [7:0] dec_db;
    // write strobes per register, used by the gain decode and the checks; wr_aux by the checks only
    logic                wr_aux;
    logic                wr_lo;
    logic                wr_ro;
    logic                wr_li;

    assign wr_aux = wr_en && addr == `AMG_AUX_B_OFS;
    assign wr_lo  = wr_en && addr == `AMG_LOUT_OFS;
    assign wr_ro  = wr_en && addr == `AMG_ROUT_OFS;
    assign wr_li  = wr_en && addr == `AMG_LIN_OFS;

    ////////////////////////////////////////////////////////////////////////////////
    // a written field is taken straight from the bus so decode lands with the store;
    // reading nxt_st here would close a loop through the process that fills it

    assign code[0] = wr_lo ? wr_data[`AMG_F_HI_LO +: 3]
                           : st_ff.lout[`AMG_F_HI_LO +: 3];
    assign code[1] = wr_lo ? wr_data[`AMG_F_MID_LO +: 3]
                           : st_ff.lout[`AMG_F_MID_LO +: 3];
    assign code[2] = wr_lo ? wr_data[`AMG_F_LOW_LO +: 3]
                           : st_ff.lout[`AMG_F_LOW_LO +: 3];
    assign code[3] = wr_ro ? wr_data[`AMG_F_TOP_LO +: 3]
                           : st_ff.rout[`AMG_F_TOP_LO +: 3];
    assign code[4] = wr_ro ? wr_data[`AMG_F_MID_LO +: 3]
                           : st_ff.rout[`AMG_F_MID_LO +: 3];
    assign code[5] = wr_ro ? wr_data[`AMG_F_LOW_LO +: 3]
                           : st_ff.rout[`AMG_F_LOW_LO +: 3];
    assign code[6] = wr_li ? wr_data[`AMG_F_HI_LO +: 3]
                           : st_ff.lin[`AMG_F_HI_LO +: 3];
    assign code[7] = wr_li ? wr_data[`AMG_F_LOW_LO +: 3]
                           : st_ff.lin[`AMG_F_LOW_LO +: 3];

    // a muted path reports 0dB gain so the analogue side never sees a stale level
    for (genvar g = 0; g < 8; g++) begin : g_dec
        assign dec_on[g] = (code[g] != `AMG_GAIN_OFF);
        assign dec_db[g] = dec_on[g] ?
            6'(`AMG_GAIN_BASE_DB + `AMG_GAIN_STEP_DB * $signed({3'h0, code[g]}))
            : 6'sh00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.rd_valid = rd_en;
        nxt_st.rd_data  = 16'h0000;
        // unsupported aux-a bit is stored and read back but drives nothing
        if (wr_en && addr == `AMG_AUX_B_OFS) begin
            nxt_st.aux_b = wr_data & `AMG_AUX_B_MASK;
        end else if (wr_en && addr == `AMG_LOUT_OFS) begin
            nxt_st.lout = wr_data & `AMG_LOUT_MASK;
        end else if (wr_en && addr == `AMG_ROUT_OFS) begin
            nxt_st.rout = wr_data & `AMG_ROUT_MASK;
        end else if (wr_en && addr == `AMG_LIN_OFS) begin
            nxt_st.lin = wr_data & `AMG_LIN_MASK;
        end
        // reads return the value held before a same-cycle write
        if (rd_en && addr == `AMG_AUX_B_OFS) begin
            nxt_st.rd_data = st_ff.aux_b;
        end else if (rd_en && addr == `AMG_LOUT_OFS) begin
            nxt_st.rd_data = st_ff.lout;
        end else if (rd_en && addr == `AMG_ROUT_OFS) begin
            nxt_st.rd_data = st_ff.rout;
        end else if (rd_en && addr == `AMG_LIN_OFS) begin
            nxt_st.rd_data = st_ff.lin;
        end
        nxt_st.path_on = dec_on;
        nxt_st.gain_db = dec_db;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state flops

    assign rd_data                   = st_ff.rd_data;
    assign rd_valid                  = st_ff.rd_valid;
    assign aux_b_mixer_enable        = st_ff.aux_b[`AMG_AUX_B_ENA_BIT];
    assign right_converter_to_aux_b  = st_ff.aux_b[`AMG_R_CONV_BIT];
    assign left_converter_to_aux_b   = st_ff.aux_b[`AMG_L_CONV_BIT];
    assign aux_b_six_db_cut          = st_ff.aux_b[`AMG_CUT_BIT];
    assign right_record_mix_to_aux_b = st_ff.aux_b[`AMG_R_REC_BIT];
    assign right_out_mix_to_aux_b    = st_ff.aux_b[`AMG_R_OUT_BIT];
    assign left_out_mix_to_aux_b     = st_ff.aux_b[`AMG_L_OUT_BIT];
    assign path_on                   = st_ff.path_on;
    assign gain_db                   = st_ff.gain_db;
    assign left_amp_record_boost     = st_ff.lin[`AMG_BOOST_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_enable;
        wr_aux |=> aux_b_mixer_enable == $past(wr_data[15]);
    endproperty
    a_enable: assert property (p_enable) else $error("aux-b enable mismatch");

    property p_conv;
        wr_aux |=> {right_converter_to_aux_b, left_converter_to_aux_b}
                   == $past(wr_data[12:11]);
    endproperty
    a_conv: assert property (p_conv) else $error("converter routing mismatch");

    property p_cut_hold;
        !wr_aux ##1 1 |-> $stable(aux_b_six_db_cut) && $stable(right_record_mix_to_aux_b);
    endproperty
    a_cut_hold: assert property (p_cut_hold) else $error("aux-b bits moved");

    property p_out_mix;
        wr_aux |=> {right_out_mix_to_aux_b, left_out_mix_to_aux_b} == $past(wr_data[1:0]);
    endproperty
    a_out_mix: assert property (p_out_mix) else $error("out mix route wrong");

    property p_mute;
        wr_lo && wr_data[11:9] == 3'h0 |=> !path_on[0] && gain_db[0] == 6'sh00;
    endproperty
    a_mute: assert property (p_mute) else $error("code zero not muted");

    property p_steps;
        wr_ro && wr_data[15:13] == 3'h4 && wr_data[7:5] == 3'h1
            |=> path_on[3] && gain_db[3] == 6'sh3d && gain_db[4] == 6'sh34;
    endproperty
    a_steps: assert property (p_steps) else $error("gain step decode wrong");

    property p_max;
        wr_li && wr_data[3:1] == 3'h7 |=> gain_db[7] == 6'sh06 && path_on[7];
    endproperty
    a_max: assert property (p_max) else $error("top gain code wrong");

    property p_left_fields;
        wr_lo && wr_data[7:5] == 3'h2 |=> gain_db[1] == 6'sh37 && path_on[1];
    endproperty
    a_left_fields: assert property (p_left_fields) else $error("left out field wrong");

    property p_boost;
        wr_li |=> left_amp_record_boost == $past(wr_data[0]);
    endproperty
    a_boost: assert property (p_boost) else $error("boost bit mismatch");

    // a read returns the word held before its edge, so it must match the pins seen there
    property p_readback;
        rd_en && addr == `AMG_AUX_B_OFS
            |=> rd_data[15] == $past(aux_b_mixer_enable) && rd_data[8:3] == 6'h00;
    endproperty
    a_readback: assert property (p_readback) else $error("aux-b read back wrong");

    property p_boost_read;
        rd_en && addr == `AMG_LIN_OFS |=> rd_data[0] == $past(left_amp_record_boost);
    endproperty
    a_boost_read: assert property (p_boost_read) else $error("boost read back wrong");

    property p_lout_read;
        rd_en && addr == `AMG_LOUT_OFS
            |=> rd_data[15:12] == 4'h0 && rd_data[8] == 1'b0 && rd_data[4] == 1'b0;
    endproperty
    a_lout_read: assert property (p_lout_read) else $error("left out spare bits set");

    c_enable: cover property (wr_aux && wr_data[15] ##1 aux_b_mixer_enable);
    c_boost:  cover property (wr_li && wr_data[0] ##1 left_amp_record_boost);
    c_read:   cover property (rd_en && addr == `AMG_LOUT_OFS ##1 rd_valid && rd_data != 16'h0);
    c_rd_wr:  cover property (wr_li && rd_en ##1 rd_valid);

endmodule : amg_regs

`default_nettype wire

// file: test/audio_mixer_route_gain_regs_test.sv
// audio_mixer_route_gain_regs_test.sv: self-checking bench for the mixer route and gain bank
// assumes: amg_pkg compiled first, amg_cfg.svh on the include path, 50 MHz clock
`include "amg_cfg.svh"
`default_nettype none

module audio_mixer_route_gain_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk, reset_n, wr_en, rd_en, rd_valid, boost;
    logic [7:0]             addr, path_on;
    logic [15:0]            wr_data, rd_data;
    logic [6:0]             aux_v;
    amg_pkg::amg_db_t [7:0] gain_db;
    int                     failures, samples_checked;

    amg_regs amg_regs_inst (
        .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .aux_b_mixer_enable(aux_v[6]), .right_converter_to_aux_b(aux_v[5]),
        .left_converter_to_aux_b(aux_v[4]), .aux_b_six_db_cut(aux_v[3]),
        .right_record_mix_to_aux_b(aux_v[2]), .right_out_mix_to_aux_b(aux_v[1]),
        .left_out_mix_to_aux_b(aux_v[0]), .path_on(path_on), .gain_db(gain_db),
        .left_amp_record_boost(boost)
    );

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1; addr <= a; wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    // rd_valid stands one cycle only, so it is sampled just after the answering edge
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd_en <= 1'b1; addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({15'h0, rd_valid}, 16'h1);
        chk(rd_data, exp);
    endtask : rd

    task automatic stop_test();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    // also run last, when every register but the left record one holds nonzero bits
    task automatic t_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk({9'h0, aux_v}, 16'h0000);
        chk({8'h0, path_on}, 16'h0000);
        chk({15'h0, boost}, 16'h0000);
        rd(`AMG_AUX_B_OFS, 16'h0000);
        rd(`AMG_LOUT_OFS, 16'h0000);
        rd(`AMG_ROUT_OFS, 16'h0000);
        rd(`AMG_LIN_OFS, 16'h0000);
    endtask : t_reset

    task automatic t_aux_bits();
        int          bits[8] = '{15, 12, 11, 10, 9, 14, 1, 0};
        logic [15:0] d;
        // host software never sets the unsupported aux-a route bit
        foreach (bits[i]) begin
            d = 16'h0001 << bits[i];
            wr(`AMG_AUX_B_OFS, d);
            chk({12'h0, aux_v[6:3]}, {12'h0, d[15], d[12:10]});
            chk({13'h0, aux_v[2:0]}, {13'h0, d[9], d[1:0]});
            rd(`AMG_AUX_B_OFS, d & 16'h9e07);
        end
        wr(`AMG_AUX_B_OFS, 16'hfffb);
        rd(`AMG_AUX_B_OFS, 16'h9e03);
    endtask : t_aux_bits

    task automatic t_gain_codes();
        logic [2:0] c;
        logic [5:0] e;
        // a different code in every field but fields 0 and 4, which both hold code 1, so a swap of any other pair cannot pass
        wr(`AMG_LOUT_OFS, 16'h0246);
        wr(`AMG_ROUT_OFS, 16'h802a);
        wr(`AMG_LIN_OFS, 16'h0c0f);
        chk({4'h0, gain_db[1], gain_db[0]}, {4'h0, 6'h37, 6'h34});
        chk({10'h0, gain_db[2]}, 16'h003a);
        chk({4'h0, gain_db[4], gain_db[3]}, {4'h0, 6'h34, 6'h3d});
        chk({10'h0, gain_db[5]}, 16'h0000);
        chk({8'h0, path_on}, 16'h00ff);
        chk({4'h0, gain_db[7], gain_db[6]}, {4'h0, 6'h06, 6'h03});
        chk({15'h0, boost}, 16'h0001);
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            e = (k == 0) ? 6'h00 : 6'(3 * k - 15);
            wr(`AMG_LOUT_OFS, {4'h0, c, 1'b0, c, 1'b0, c, 1'b0});
            wr(`AMG_ROUT_OFS, {c, 5'h00, c, 1'b0, c, 1'b0});
            wr(`AMG_LIN_OFS, {4'h0, c, 5'h00, c, c[0]});
            for (int i = 0; i < 8; i++) begin
                chk({10'h0, gain_db[i]}, {10'h0, e});
            end
            chk({8'h0, path_on}, {8'h0, {8{k != 0}}});
            chk({15'h0, boost}, {15'h0, c[0]});
            rd(`AMG_ROUT_OFS, {c, 5'h00, c, 1'b0, c, 1'b0});
        end
    endtask : t_gain_codes

    // unmapped place beside a real one, then a read and write taken at the same edge
    task automatic t_port_edges();
        wr(8'h5e, 16'hffff);
        rd(8'h5e, 16'h0000);
        rd(`AMG_LOUT_OFS, 16'h0eee);
        @(posedge clk);
        rd_en <= 1'b1; wr_en <= 1'b1; addr <= `AMG_LIN_OFS; wr_data <= 16'h0000;
        @(posedge clk);
        rd_en <= 1'b0; wr_en <= 1'b0;
        #1;
        chk(rd_data, 16'h0e0f);
        chk({15'h0, boost}, 16'h0000);
        rd(`AMG_LIN_OFS, 16'h0000);
    endtask : t_port_edges

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0; reset_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0;
        addr = 8'h00; wr_data = 16'h0000;
        failures = 0; samples_checked = 0;
        t_reset();
        t_aux_bits();
        t_gain_codes();
        t_port_edges();
        t_reset();
        stop_test();
    end

    // the tests need well under 1000 cycles; 10000 leaves ample margin
    initial begin
        #200000;
        failures++;
        stop_test();
    end

endmodule : audio_mixer_route_gain_regs_test

`default_nettype wire
